// >>> pkg/qtmr_params.svh
// constants of the four-channel 8-bit timer unit
// assumes a 32-bit apb slave; register index sits in paddr[21:2]
`ifndef QTMR_PARAMS_SVH
`define QTMR_PARAMS_SVH

// register indexes; byte address is four times the index
`define QTMR_IDX_CH0_CONTROL  20'hfff80
`define QTMR_IDX_CH1_CONTROL  20'hfff81
`define QTMR_IDX_CH0_STATUS   20'hfff82
`define QTMR_IDX_CH1_STATUS   20'hfff83
`define QTMR_IDX_CH0_CONST_A  20'hfff84
`define QTMR_IDX_CH1_CONST_A  20'hfff85
`define QTMR_IDX_CH0_CONST_B  20'hfff86
`define QTMR_IDX_CH1_CONST_B  20'hfff87
`define QTMR_IDX_CH0_COUNTER  20'hfff88
`define QTMR_IDX_CH1_COUNTER  20'hfff89
`define QTMR_IDX_CH2_CONTROL  20'hfff90
`define QTMR_IDX_CH3_CONTROL  20'hfff91
`define QTMR_IDX_CH2_STATUS   20'hfff92
`define QTMR_IDX_CH3_STATUS   20'hfff93
`define QTMR_IDX_CH2_CONST_A  20'hfff94
`define QTMR_IDX_CH3_CONST_A  20'hfff95
`define QTMR_IDX_CH2_CONST_B  20'hfff96
`define QTMR_IDX_CH3_CONST_B  20'hfff97
`define QTMR_IDX_CH2_COUNTER  20'hfff98
`define QTMR_IDX_CH3_COUNTER  20'hfff99

// address slicing
`define QTMR_IDX_MSB          21
`define QTMR_IDX_LSB          2
`define QTMR_PAIR_BIT         22

// control fields
`define QTMR_CTL_IE_B         7
`define QTMR_CTL_IE_A         6
`define QTMR_CTL_IE_OVF       5
`define QTMR_CTL_CLR_MSB      4
`define QTMR_CTL_CLR_LSB      3
`define QTMR_CTL_CKS_MSB      2

// control/status fields
`define QTMR_ST_FLAG_B        7
`define QTMR_ST_FLAG_A        6
`define QTMR_ST_FLAG_OVF      5
`define QTMR_ST_AUX           4
`define QTMR_ST_OUT_B_LSB     2
`define QTMR_ST_FLAG_LSB      5

// reset values
`define QTMR_RST_ZERO         8'h00
`define QTMR_RST_CONST        8'hff

// prescaler taps
`define QTMR_DIV_FAST_BITS    3
`define QTMR_DIV_MID_BITS     6
`define QTMR_DIV_SLOW         8192

`endif

// >>> pkg/qtmr_pkg.sv
// types of the four-channel 8-bit timer unit
// assumes qtmr_params.svh holds the numeric constants
package qtmr_pkg;

	typedef enum logic [2:0] {
		cks_off       = 3'h0,
		cks_div_fast  = 3'h1,
		cks_div_mid   = 3'h2,
		cks_div_slow  = 3'h3,
		cks_chain     = 3'h4,
		cks_ext_rise  = 3'h5,
		cks_ext_fall  = 3'h6,
		cks_ext_both  = 3'h7
	} qtmr_cks_type;

	typedef enum logic [1:0] {
		clr_none      = 2'h0,
		clr_match_a   = 2'h1,
		clr_b_any     = 2'h2,
		clr_capture   = 2'h3
	} qtmr_clr_type;

	typedef enum logic [1:0] {
		out_keep      = 2'h0,
		out_low       = 2'h1,
		out_high      = 2'h2,
		out_toggle    = 2'h3
	} qtmr_out_type;

	typedef enum logic [2:0] {
		kind_control  = 3'h0,
		kind_status   = 3'h1,
		kind_const_a  = 3'h2,
		kind_const_b  = 3'h3,
		kind_counter  = 3'h4
	} qtmr_kind_type;

endpackage

// >>> verilog/qtmr_top.sv
// four-channel 8-bit timer unit with apb register access
// assumes a single 50 mhz pclk; timer pins arrive asynchronously
//
// Added by the designer: the APB register port.
`timescale 1ns/100ps
`include "qtmr_params.svh"

module qtmr_top #(
	parameter int unsigned DIV_SLOW = `QTMR_DIV_SLOW
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// timer pins
	output logic             match_out_ch0,
	output logic             match_out_ch2,
	input  wire logic        match_capture_pin_ch1_in,
	output logic             match_capture_pin_ch1_out,
	output logic             match_capture_pin_ch1_oe,
	input  wire logic        match_capture_pin_ch3_in,
	output logic             match_capture_pin_ch3_out,
	output logic             match_capture_pin_ch3_oe,
	input  wire logic        ext_count_clock_a,
	input  wire logic        ext_count_clock_b,
	input  wire logic        ext_count_clock_c,
	input  wire logic        ext_count_clock_d,
	// converter start and request vectors
	output logic             adc_start,
	output logic [7:0]       irq_vec
);
	import qtmr_pkg::*;

	localparam int NCH = 4;
	localparam int PW  = $clog2(DIV_SLOW);

	logic [NCH-1:0][7:0] ctrl;
	logic [NCH-1:0][7:0] csr;
	logic [NCH-1:0][7:0] ca;
	logic [NCH-1:0][7:0] cb;
	logic [NCH-1:0][7:0] cnt;
	logic [NCH-1:0][7:0] wbyte;
	logic [NCH-1:0][2:0] ext_s;
	logic [NCH-1:0]      ext_in;
	logic [NCH-1:0]      inc;
	logic [NCH-1:0]      clr;
	logic [NCH-1:0]      ma_p;
	logic [NCH-1:0]      mb_p;
	logic [NCH-1:0]      ovf_p;
	logic [NCH-1:0]      cap_p;
	logic [NCH-1:0]      cap_now;
	logic [NCH-1:0]      eqa_q;
	logic [NCH-1:0]      eqb_q;
	logic [NCH-1:0]      pin_out;
	logic [NCH-1:0]      sel;
	logic [NCH-1:0]      wr_ctrl;
	logic [NCH-1:0]      wr_csr;
	logic [NCH-1:0]      wr_ca;
	logic [NCH-1:0]      wr_cb;
	logic [NCH-1:0]      wr_cnt;
	logic [1:0]          pin_oe;
	logic [PW-1:0]       pre;
	logic                tick_fast;
	logic                tick_mid;
	logic                tick_slow;
	logic [19:0]         idx;
	logic                pair;
	logic                grp;
	logic [3:0]          sub;
	logic                hit;
	logic                wr_en;
	qtmr_kind_type       kind;
	logic [31:0]         next_rdata;

	default clocking cb_clk @(posedge pclk); endclocking
	default disable iff (!presetn);

	// pin map: ch0 c, ch1 a, ch2 d, ch3 b
	assign ext_in = {ext_count_clock_b, ext_count_clock_d, ext_count_clock_a, ext_count_clock_c};

	// prescaler; taps are one-cycle enables, never clocks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre <= '0;
		end else if (pre == PW'(DIV_SLOW - 1)) begin
			pre <= '0;
		end else begin
			pre <= pre + PW'(1);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_fast <= 1'b0;
			tick_mid  <= 1'b0;
			tick_slow <= 1'b0;
		end else begin
			tick_fast <= &pre[`QTMR_DIV_FAST_BITS-1:0];
			tick_mid  <= &pre[`QTMR_DIV_MID_BITS-1:0];
			tick_slow <= (pre == PW'(DIV_SLOW - 1));
		end
	end

	sequence fast_gap_s;
		!tick_fast [*7] ##1 tick_fast;
	endsequence
	prescale_tick_a: assert property (tick_fast |=> fast_gap_s)
		else $error("fast tap not every eighth cycle");

	// address decode
	assign idx  = paddr[`QTMR_IDX_MSB:`QTMR_IDX_LSB];
	assign pair = paddr[`QTMR_PAIR_BIT];
	assign grp  = idx[4];
	assign sub  = idx[3:0];
	assign kind = qtmr_kind_type'(sub[3:1]);
	assign hit  = ({idx[19:5], 5'h00} == `QTMR_IDX_CH0_CONTROL) && (paddr[31:23] == 9'h000)
		&& (paddr[1:0] == 2'h0)
		&& (sub <= 4'(`QTMR_IDX_CH1_COUNTER - `QTMR_IDX_CH0_CONTROL))
		&& !(pair && sub[0]);
	assign wr_en = psel && penable && pready && pwrite;

	function automatic logic [7:0] reg_of(input logic [1:0] c);
		logic [7:0] v;
		v = 8'h00;
		unique case (kind)
			kind_control: v = ctrl[c];
			kind_status:  v = csr[c];
			kind_const_a: v = ca[c];
			kind_const_b: v = cb[c];
			kind_counter: v = cnt[c];
			default:      v = 8'h00;
		endcase
		return v;
	endfunction

	always_comb begin
		next_rdata = 32'h0000_0000;
		if (hit && pair) begin
			next_rdata[15:0] = {reg_of({grp, 1'b0}), reg_of({grp, 1'b1})};
		end else if (hit) begin
			next_rdata[7:0] = reg_of({grp, sub[0]});
		end
	end

	// zero-wait slave: setup captures read data, access answers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready <= psel && !penable;
			if (psel && !penable) begin
				pslverr <= !hit;
				prdata  <= pwrite ? 32'h0000_0000 : next_rdata;
			end
		end
	end

	sequence setup_s;
		psel && !penable;
	endsequence
	sequence answer_s;
		penable && pready;
	endsequence
	apb_answer_a: assert property (setup_s |=> answer_s ##1 !pready)
		else $error("apb answer not in first access cycle");

	for (genvar ch = 0; ch < NCH; ch++) begin : chan
		localparam int PEER = ch ^ 1;
		localparam bit ODD  = (ch % 2) == 1;

		// pair write: even channel takes the upper byte lane
		always_comb begin
			sel[ch]   = hit && (grp == 1'(ch / 2)) && (pair || (sub[0] == ODD));
			wbyte[ch] = (pair && !ODD) ? pwdata[15:8] : pwdata[7:0];
			wr_ctrl[ch] = 1'b0;
			wr_csr[ch]  = 1'b0;
			wr_ca[ch]   = 1'b0;
			wr_cb[ch]   = 1'b0;
			wr_cnt[ch]  = 1'b0;
			if (wr_en && sel[ch] && ((pair && !ODD) ? pstrb[1] : pstrb[0])) begin
				wr_ctrl[ch] = (kind == kind_control);
				wr_csr[ch]  = (kind == kind_status);
				wr_ca[ch]   = (kind == kind_const_a);
				wr_cb[ch]   = (kind == kind_const_b);
				wr_cnt[ch]  = (kind == kind_counter);
			end
		end

		// first stage is read only by the second
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				ext_s[ch] <= 3'h0;
			end else begin
				ext_s[ch] <= {ext_s[ch][1:0], ext_in[ch]};
			end
		end

		always_comb begin
			unique case (qtmr_cks_type'(ctrl[ch][`QTMR_CTL_CKS_MSB:0]))
				cks_off:      inc[ch] = 1'b0;
				cks_div_fast: inc[ch] = tick_fast;
				cks_div_mid:  inc[ch] = tick_mid;
				cks_div_slow: inc[ch] = tick_slow;
				cks_chain:    inc[ch] = ODD ? ma_p[PEER] : ovf_p[PEER];
				cks_ext_rise: inc[ch] = ext_s[ch][1] && !ext_s[ch][2];
				cks_ext_fall: inc[ch] = !ext_s[ch][1] && ext_s[ch][2];
				cks_ext_both: inc[ch] = ext_s[ch][1] ^ ext_s[ch][2];
			endcase
			unique case (qtmr_clr_type'(ctrl[ch][`QTMR_CTL_CLR_MSB:`QTMR_CTL_CLR_LSB]))
				clr_none:    clr[ch] = 1'b0;
				clr_match_a: clr[ch] = ma_p[ch];
				clr_b_any:   clr[ch] = mb_p[ch] || cap_p[ch];
				clr_capture: clr[ch] = cap_p[ch];
			endcase
		end

		// capture: odd channel watches its pin, even follows when chained
		if (ODD) begin : cap_pin
			logic [2:0] cap_s;
			logic       pin_in;
			assign pin_in = (ch == 1) ? match_capture_pin_ch1_in : match_capture_pin_ch3_in;
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cap_s <= 3'h0;
				end else begin
					cap_s <= {cap_s[1:0], pin_in};
				end
			end
			always_comb begin
				unique case (csr[ch][3:2])
					2'h0: cap_now[ch] = 1'b0;
					2'h1: cap_now[ch] = cap_s[1] && !cap_s[2];
					2'h2: cap_now[ch] = !cap_s[1] && cap_s[2];
					2'h3: cap_now[ch] = cap_s[1] ^ cap_s[2];
				endcase
				cap_now[ch] = cap_now[ch] && csr[ch][`QTMR_ST_AUX];
			end
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					pin_oe[ch/2] <= 1'b0;
				end else begin
					pin_oe[ch/2] <= !csr[ch][`QTMR_ST_AUX];
				end
			end
		end else begin : cap_follow
			assign cap_now[ch] = cap_now[PEER]
				&& (ctrl[ch][`QTMR_CTL_CKS_MSB:0] == cks_chain);
		end

		// compare events are edges of equality, so a held value counts once
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				eqa_q[ch] <= 1'b0;
				eqb_q[ch] <= 1'b0;
				ma_p[ch]  <= 1'b0;
				mb_p[ch]  <= 1'b0;
				cap_p[ch] <= 1'b0;
				ovf_p[ch] <= 1'b0;
			end else begin
				eqa_q[ch] <= (cnt[ch] == ca[ch]);
				eqb_q[ch] <= (cnt[ch] == cb[ch]);
				ma_p[ch]  <= (cnt[ch] == ca[ch]) && !eqa_q[ch];
				mb_p[ch]  <= (cnt[ch] == cb[ch]) && !eqb_q[ch]
					&& !(ODD && csr[ch][`QTMR_ST_AUX]);
				cap_p[ch] <= cap_now[ch];
				ovf_p[ch] <= inc[ch] && (cnt[ch] == 8'hff) && !wr_cnt[ch] && !clr[ch];
			end
		end

		// software write beats clearing, clearing beats counting
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				cnt[ch] <= `QTMR_RST_ZERO;
			end else if (wr_cnt[ch]) begin
				cnt[ch] <= wbyte[ch];
			end else if (clr[ch]) begin
				cnt[ch] <= 8'h00;
			end else if (inc[ch]) begin
				cnt[ch] <= cnt[ch] + 8'h01;
			end
		end

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				ctrl[ch] <= `QTMR_RST_ZERO;
				ca[ch]   <= `QTMR_RST_CONST;
				cb[ch]   <= `QTMR_RST_CONST;
			end else begin
				if (wr_ctrl[ch]) begin
					ctrl[ch] <= wbyte[ch];
				end
				if (wr_ca[ch]) begin
					ca[ch] <= wbyte[ch];
				end
				if (wr_cb[ch]) begin
					cb[ch] <= wbyte[ch];
				end else if (cap_now[ch]) begin
					cb[ch] <= cnt[ch];
				end
			end
		end

		// flags: hardware set wins over a written zero in the same cycle
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				csr[ch] <= `QTMR_RST_ZERO;
			end else begin
				if (wr_csr[ch]) begin
					csr[ch][`QTMR_ST_FLAG_LSB-1:0] <= wbyte[ch][`QTMR_ST_FLAG_LSB-1:0];
				end
				csr[ch][`QTMR_ST_FLAG_B] <= (csr[ch][`QTMR_ST_FLAG_B]
					&& !(wr_csr[ch] && !wbyte[ch][`QTMR_ST_FLAG_B]))
					|| mb_p[ch] || cap_now[ch];
				csr[ch][`QTMR_ST_FLAG_A] <= (csr[ch][`QTMR_ST_FLAG_A]
					&& !(wr_csr[ch] && !wbyte[ch][`QTMR_ST_FLAG_A]))
					|| ma_p[ch];
				csr[ch][`QTMR_ST_FLAG_OVF] <= (csr[ch][`QTMR_ST_FLAG_OVF]
					&& !(wr_csr[ch] && !wbyte[ch][`QTMR_ST_FLAG_OVF]))
					|| ovf_p[ch];
			end
		end

		// simultaneous a and b matches leave the output alone
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				pin_out[ch] <= 1'b0;
			end else if (ma_p[ch] != mb_p[ch]) begin
				unique case (qtmr_out_type'(ma_p[ch] ? csr[ch][1:0]
					: csr[ch][`QTMR_ST_OUT_B_LSB+1:`QTMR_ST_OUT_B_LSB]))
					out_keep:   pin_out[ch] <= pin_out[ch];
					out_low:    pin_out[ch] <= 1'b0;
					out_high:   pin_out[ch] <= 1'b1;
					out_toggle: pin_out[ch] <= !pin_out[ch];
				endcase
			end
		end
	end

	assign match_out_ch0             = pin_out[0];
	assign match_out_ch2             = pin_out[2];
	assign match_capture_pin_ch1_out = pin_out[1];
	assign match_capture_pin_ch3_out = pin_out[3];
	assign match_capture_pin_ch1_oe  = pin_oe[0];
	assign match_capture_pin_ch3_oe  = pin_oe[1];

	// converter start only from even channels; odd use that bit for capture
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			adc_start <= 1'b0;
		end else begin
			adc_start <= (ma_p[0] && csr[0][`QTMR_ST_AUX])
				|| (ma_p[2] && csr[2][`QTMR_ST_AUX]);
		end
	end

	// per group: a, b own vectors; odd a|b shared; overflows shared
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_vec <= 8'h00;
		end else begin
			for (int g = 0; g < 2; g++) begin
				irq_vec[4*g]   <= csr[2*g][`QTMR_ST_FLAG_A] && ctrl[2*g][`QTMR_CTL_IE_A];
				irq_vec[4*g+1] <= csr[2*g][`QTMR_ST_FLAG_B] && ctrl[2*g][`QTMR_CTL_IE_B];
				irq_vec[4*g+2] <= (csr[2*g+1][`QTMR_ST_FLAG_A] && ctrl[2*g+1][`QTMR_CTL_IE_A])
					|| (csr[2*g+1][`QTMR_ST_FLAG_B] && ctrl[2*g+1][`QTMR_CTL_IE_B]);
				irq_vec[4*g+3] <= (csr[2*g][`QTMR_ST_FLAG_OVF] && ctrl[2*g][`QTMR_CTL_IE_OVF])
					|| (csr[2*g+1][`QTMR_ST_FLAG_OVF]
					&& ctrl[2*g+1][`QTMR_CTL_IE_OVF]);
			end
		end
	end

	ovf_flag_set_a: assert property (ovf_p[3] |=> csr[3][`QTMR_ST_FLAG_OVF])
		else $error("overflow flag not set");
	match_a_flag_a: assert property (ma_p[0] |=> csr[0][`QTMR_ST_FLAG_A])
		else $error("match a flag not set");
	count_step_a: assert property (inc[0] && !clr[0] && !wr_cnt[0]
		|=> cnt[0] == $past(cnt[0]) + 8'h01)
		else $error("counter did not step by one");
	clear_on_a_a: assert property (ctrl[0][4:3] == 2'h1 && ma_p[0] && !wr_cnt[0]
		|=> cnt[0] == 8'h00)
		else $error("counter not cleared by match a");
	capture_copy_a: assert property (cap_now[1] && !wr_cb[1]
		|=> cb[1] == $past(cnt[1]) && csr[1][`QTMR_ST_FLAG_B])
		else $error("capture did not load constant b");
	flag_clear_a: assert property (wr_csr[0] && !wbyte[0][`QTMR_ST_FLAG_A] && !ma_p[0]
		|=> !csr[0][`QTMR_ST_FLAG_A])
		else $error("written zero did not clear flag");
	chain_count_a: assert property (ctrl[2][2:0] == 3'h4 && ovf_p[3] |-> inc[2])
		else $error("upper half missed lower overflow");
	out_high_a: assert property (ma_p[0] && !mb_p[0] && csr[0][1:0] == 2'h2
		|=> match_out_ch0)
		else $error("output not driven high on match a");
	adc_trigger_a: assert property (ma_p[0] && csr[0][`QTMR_ST_AUX] |=> adc_start)
		else $error("converter start missing");
	irq_route_a: assert property (csr[3][`QTMR_ST_FLAG_OVF] && ctrl[3][`QTMR_CTL_IE_OVF]
		|=> irq_vec[7])
		else $error("overflow request not raised");

endmodule

// >>> testbench/qtmr_pins_model.sv
// pin-side partner: external count clocks, capture inputs, converter start counter
// assumes the timer unit passes its pins through its own synchronisers
`timescale 1ns/100ps

module qtmr_pins_model (
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// two-way pins of the odd channels
	input  wire logic       pin1_out,
	input  wire logic       pin1_oe,
	input  wire logic       pin3_out,
	input  wire logic       pin3_oe,
	output logic            pin1_in,
	output logic            pin3_in,
	// count clocks a, b, c, d and converter start
	output logic      [3:0] ext_clk,
	input  wire logic       adc_start,
	output logic      [7:0] adc_count
);
	logic [1:0] cap_drv;

	initial begin
		ext_clk = 4'h0;
		cap_drv = 2'h0;
	end
	// the pin shows the model's level only while the timer leaves it undriven
	assign pin1_in = pin1_oe ? pin1_out : cap_drv[0];
	assign pin3_in = pin3_oe ? pin3_out : cap_drv[1];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			adc_count <= 8'h00;
		end else if (adc_start) begin
			adc_count <= adc_count + 8'h01;
		end
	end
	// each level held at least 8 cycles so the synchronisers cannot miss an edge
	task automatic pulse(input int pin, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge pclk);
			ext_clk[pin] <= 1'b1;
			repeat (8) @(posedge pclk);
			ext_clk[pin] <= 1'b0;
			repeat (8) @(posedge pclk);
		end
	endtask
	task automatic capture(input int ch);
		@(posedge pclk);
		cap_drv[ch] <= 1'b1;
		repeat (8) @(posedge pclk);
	endtask
endmodule

// >>> testbench/quad_eight_bit_timer_unit_tb_top.sv
// testbench of the four-channel timer: apb register calls with expected values
// assumes qtmr_top with a shortened slow tap and the pin model beside it
`timescale 1ns/100ps
`include "qtmr_params.svh"
`define CHECK(got, exp) \
	begin \
		total_checks++; \
		if ((got) !== (exp)) begin \
			miscompares++; \
			$display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); \
		end \
	end

module quad_eight_bit_timer_unit_tb_top;
	localparam logic [31:0] pair = 32'h0040_0000;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [31:0] paddr, pwdata, prdata, rdat;
	logic [3:0]  pstrb, ext_clk;
	logic        mo0, mo2, p1_in, p1_out, p1_oe, p3_in, p3_out, p3_oe, adc_start;
	logic [7:0]  irq_vec, adc_count;
	logic        rerr;
	int          miscompares, total_checks, cycles;
	int          div[4] = '{0, 8, 64, 128};
	logic [7:0]  mode[3] = '{8'h05, 8'h07, 8'h06};
	int          npl[3] = '{7, 3, 2};
	logic [7:0]  cnt[3] = '{8'd7, 8'd13, 8'd15};
	logic [7:0]  clr[4] = '{8'd6, 8'd2, 8'd1, 8'd6};

	qtmr_top #(.DIV_SLOW(128)) dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.match_out_ch0(mo0), .match_out_ch2(mo2),
		.match_capture_pin_ch1_in(p1_in), .match_capture_pin_ch1_out(p1_out),
		.match_capture_pin_ch1_oe(p1_oe), .match_capture_pin_ch3_in(p3_in),
		.match_capture_pin_ch3_out(p3_out), .match_capture_pin_ch3_oe(p3_oe),
		.ext_count_clock_a(ext_clk[0]), .ext_count_clock_b(ext_clk[1]),
		.ext_count_clock_c(ext_clk[2]), .ext_count_clock_d(ext_clk[3]),
		.adc_start(adc_start), .irq_vec(irq_vec));
	qtmr_pins_model model_u (
		.pclk(pclk), .presetn(presetn), .pin1_out(p1_out), .pin1_oe(p1_oe),
		.pin3_out(p3_out), .pin3_oe(p3_oe), .pin1_in(p1_in), .pin3_in(p3_in),
		.ext_clk(ext_clk), .adc_start(adc_start), .adc_count(adc_count));

	always #10 pclk = ~pclk;

	function automatic logic [31:0] ba(input logic [19:0] i);
		return {10'h000, i, 2'b00};
	endfunction
	task automatic report_and_stop;
		if (miscompares == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// a hang in a wait counts as a mismatch; the run needs well under this
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			report_and_stop;
		end
	end
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [19:0] i, input logic [7:0] d);
		apb(1'b1, ba(i), {24'h0, d}, 4'h1);
	endtask
	task automatic rd(input logic [19:0] i);
		apb(1'b0, ba(i), 32'h0, 4'h0);
	endtask
	task automatic chk(input logic [19:0] i, input logic [7:0] e);
		rd(i);
		`CHECK(rdat, {24'h0, e})
	endtask

	initial begin
		{pclk, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
		presetn = 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		for (int g = 0; g < 2; g++) begin
			for (int k = 0; k < 10; k++) begin
				chk(20'(32'hfff80 + g * 16 + k), (k > 3 && k < 8) ? 8'hff : 8'h00);
			end
		end
		rd(20'hfff8a);
		`CHECK({rerr, rdat}, 33'h1_0000_0000)
		apb(1'b0, ba(`QTMR_IDX_CH1_CONST_A) | pair, 32'h0, 4'h0);
		`CHECK(rerr, 1'b1)
		apb(1'b1, ba(`QTMR_IDX_CH0_CONST_A) | pair, 32'h1234, 4'h3);
		chk(`QTMR_IDX_CH0_CONST_A, 8'h12);
		chk(`QTMR_IDX_CH1_CONST_A, 8'h34);
		wr(`QTMR_IDX_CH0_CONST_A, 8'h05);
		for (int t = 1; t < 4; t++) begin
			wr(`QTMR_IDX_CH0_COUNTER, 8'h00);
			wr(`QTMR_IDX_CH0_CONTROL, 8'(t));
			repeat (div[t] * 10 - 3) @(posedge pclk);
			wr(`QTMR_IDX_CH0_CONTROL, 8'h00);
			rd(`QTMR_IDX_CH0_COUNTER);
			`CHECK(rdat[7:0] inside {8'd9, 8'd10, 8'd11}, 1'b1)
		end
		chk(`QTMR_IDX_CH0_STATUS, 8'h40);
		wr(`QTMR_IDX_CH0_STATUS, 8'he0);
		chk(`QTMR_IDX_CH0_STATUS, 8'h40);
		wr(`QTMR_IDX_CH0_STATUS, 8'h00);
		chk(`QTMR_IDX_CH0_STATUS, 8'h00);
		for (int m = 0; m < 3; m++) begin
			wr(`QTMR_IDX_CH1_CONTROL, mode[m]);
			model_u.pulse(0, npl[m]);
			chk(`QTMR_IDX_CH1_COUNTER, cnt[m]);
		end
		wr(`QTMR_IDX_CH1_STATUS, 8'h14);
		// the enable follows the status write one edge later; look once it has settled
		repeat (2) @(posedge pclk);
		`CHECK(p1_oe, 1'b0)
		`CHECK(p3_oe, 1'b1)
		model_u.capture(0);
		chk(`QTMR_IDX_CH1_CONST_B, 8'h0f);
		chk(`QTMR_IDX_CH1_STATUS, 8'h94);
		wr(`QTMR_IDX_CH2_CONST_A, 8'h04);
		wr(`QTMR_IDX_CH2_CONST_B, 8'h05);
		wr(`QTMR_IDX_CH2_STATUS, 8'h02);
		for (int c = 0; c < 4; c++) begin
			wr(`QTMR_IDX_CH2_COUNTER, 8'h00);
			wr(`QTMR_IDX_CH2_CONTROL, 8'(c * 8 + 5));
			model_u.pulse(3, 6);
			chk(`QTMR_IDX_CH2_COUNTER, clr[c]);
		end
		chk(`QTMR_IDX_CH2_STATUS, 8'hc2);
		`CHECK(mo2, 1'b1)
		wr(`QTMR_IDX_CH0_CONTROL, 8'h05);
		wr(`QTMR_IDX_CH0_COUNTER, 8'h00);
		wr(`QTMR_IDX_CH0_CONST_A, 8'h02);
		wr(`QTMR_IDX_CH0_CONST_B, 8'h04);
		wr(`QTMR_IDX_CH0_STATUS, 8'h16);
		model_u.pulse(2, 2);
		`CHECK(mo0, 1'b1)
		model_u.pulse(2, 2);
		`CHECK(mo0, 1'b0)
		`CHECK(adc_count != 8'h00, 1'b1)
		wr(`QTMR_IDX_CH0_CONTROL, 8'h0d);
		wr(`QTMR_IDX_CH0_CONST_A, 8'h01);
		wr(`QTMR_IDX_CH0_COUNTER, 8'h00);
		wr(`QTMR_IDX_CH1_COUNTER, 8'h00);
		wr(`QTMR_IDX_CH1_CONTROL, 8'h04);
		model_u.pulse(2, 6);
		chk(`QTMR_IDX_CH1_COUNTER, 8'h06);
		apb(1'b1, ba(`QTMR_IDX_CH2_CONST_A) | pair, 32'h0480, 4'h3);
		apb(1'b1, ba(`QTMR_IDX_CH2_CONST_B) | pair, 32'h0580, 4'h3);
		apb(1'b1, ba(`QTMR_IDX_CH2_COUNTER) | pair, 32'h00fe, 4'h3);
		wr(`QTMR_IDX_CH3_CONTROL, 8'h25);
		wr(`QTMR_IDX_CH2_CONTROL, 8'h04);
		model_u.pulse(1, 3);
		apb(1'b0, ba(`QTMR_IDX_CH2_COUNTER) | pair, 32'h0, 4'h0);
		`CHECK(rdat, 32'h0000_0101)
		chk(`QTMR_IDX_CH3_STATUS, 8'h20);
		`CHECK(irq_vec, 8'h80)
		wr(`QTMR_IDX_CH3_STATUS, 8'h00);
		repeat (2) @(posedge pclk);
		`CHECK(irq_vec, 8'h00)
		report_and_stop;
	end
endmodule
